// *** design/pca_channel.sv ***
// One capture/compare module: value register, capture, match, toggle, PWM
`timescale 1ns/1ps
`default_nettype none
module pca_channel (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] mode_i,
  input wire logic [15:0] counter_i,
  input wire logic count_step_i,
  input wire logic pin_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  output logic [15:0] value_o,
  output logic event_o,
  output logic pin_o,
  output logic pin_oe_o
);
  logic pin_prev;
  logic [15:0] next_value;
  logic rise;
  logic fall;
  logic capture;
  logic match_hit;
  logic toggle_hit;
  logic low_wrap;
  logic pwm_active;
  logic pwm_level;
  logic next_pin;

  assign rise = pin_i & ~pin_prev;
  assign fall = ~pin_i & pin_prev;
  assign capture = (rise & mode_i[pca_pkg::MODE_RISE_BIT]) |
                   (fall & mode_i[pca_pkg::MODE_FALL_BIT]);
  // match only when counter just stepped
  assign match_hit = count_step_i & mode_i[pca_pkg::MODE_COMP_BIT] &
                     (counter_i == value_o);
  assign toggle_hit = match_hit & mode_i[pca_pkg::MODE_TOG_BIT];
  assign low_wrap = count_step_i & (counter_i[7:0] == pca_pkg::BYTE_ZERO);
  assign pwm_active = mode_i[pca_pkg::MODE_PWM_BIT] &
                      mode_i[pca_pkg::MODE_COMP_BIT];
  assign pwm_level = (counter_i[7:0] >= value_o[7:0]);
  assign event_o = capture | (match_hit & mode_i[pca_pkg::MODE_MAT_BIT]);

  // capture, reload; hardware wins over software
  always_comb begin
    next_value = value_o;
    if (wr_lo_i) next_value[7:0] = wdata_i;
    if (wr_hi_i) next_value[15:8] = wdata_i;
    if (pwm_active && low_wrap) next_value[7:0] = value_o[15:8];
    if (capture) next_value = counter_i;
  end

  assign next_pin = pwm_active ? pwm_level :
                    toggle_hit ? ~pin_o : pin_o;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= pca_pkg::WORD_ZERO;
      pin_prev <= pca_pkg::PIN_IDLE;
      pin_o <= pca_pkg::PIN_IDLE;
      pin_oe_o <= 1'b0;
    end else begin
      value_o <= next_value;
      pin_prev <= pin_i;
      pin_o <= next_pin;
      pin_oe_o <= pwm_active | (mode_i[pca_pkg::MODE_TOG_BIT] &
                                mode_i[pca_pkg::MODE_COMP_BIT]);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_capture_loads_count: assert property (
    capture |=> value_o == $past(counter_i))
    else $error("capture did not load counter");
  a_pwm_output_level: assert property (
    pwm_active |=> pin_o == $past(pwm_level))
    else $error("PWM level wrong");
  a_match_toggles_pin: assert property (
    toggle_hit && !pwm_active |=> pin_o != $past(pin_o))
    else $error("pin did not toggle on match");
  a_match_sets_event: assert property (
    count_step_i && mode_i[pca_pkg::MODE_COMP_BIT] &&
    mode_i[pca_pkg::MODE_MAT_BIT] && counter_i == value_o |-> event_o)
    else $error("match event missing");
  c_capture_seen: cover property (capture);
  c_pwm_reload: cover property (pwm_active && low_wrap);
endmodule
`default_nettype wire

// *** design/pca_pkg.sv ***
// Constants, addresses and decode helpers for the counter array
package pca_pkg;
  localparam int NUM_MODULES = 5;
  localparam int WDOG_MODULE = 4;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_IE = 8'hA8;
  localparam logic [7:0] ADDR_CONTROL = 8'hC0;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'hC1;
  localparam logic [7:0] ADDR_COUNT_LO = 8'hC2;
  localparam logic [7:0] ADDR_COUNT_HI = 8'hC3;
  localparam logic [7:0] ADDR_MODE_BASE = 8'hC8;
  localparam logic [7:0] ADDR_VALUE_LO_BASE = 8'hD0;
  localparam logic [7:0] ADDR_VALUE_HI_BASE = 8'hD8;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  // Mode configuration fields
  localparam int CFG_IDLE_BIT = 7;
  localparam int CFG_WDOG_BIT = 6;
  localparam int CFG_SRC_HI_BIT = 2;
  localparam int CFG_SRC_LO_BIT = 1;
  localparam int CFG_OVF_IRQ_BIT = 0;
  localparam int IE_COUNTER_ARRAY_BIT = 6;
  // Module mode fields
  localparam int MODE_IRQ_BIT = 0;
  localparam int MODE_PWM_BIT = 1;
  localparam int MODE_TOG_BIT = 2;
  localparam int MODE_MAT_BIT = 3;
  localparam int MODE_FALL_BIT = 4;
  localparam int MODE_RISE_BIT = 5;
  localparam int MODE_COMP_BIT = 6;

  localparam logic [7:0] CFG_WRITE_MASK = 8'hC7;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h7F;

  // Count sources
  localparam logic [1:0] SRC_OSC_SLOW = 2'h0;
  localparam logic [1:0] SRC_OSC_FAST = 2'h1;
  localparam logic [1:0] SRC_TIMER0 = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  localparam logic [3:0] DIV_SLOW_X6 = 4'h6;
  localparam logic [3:0] DIV_SLOW_X12 = 4'hC;
  localparam logic [3:0] DIV_FAST_X6 = 4'h2;
  localparam logic [3:0] DIV_FAST_X12 = 4'h4;
  localparam logic [3:0] DIV_ONE = 4'h1;
  localparam logic [3:0] DIV_ZERO = 4'h0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic PIN_IDLE = 1'b1;

  function automatic logic [7:0] chan_offset(input logic [7:0] addr,
                                             input logic [7:0] base);
    chan_offset = addr - base;
  endfunction

  // True when addr falls in the per-module block starting at base
  function automatic logic chan_hit(input logic [7:0] addr,
                                    input logic [7:0] base);
    logic [7:0] off;
    off = chan_offset(addr, base);
    chan_hit = (off < 8'(NUM_MODULES));
  endfunction
endpackage

// *** design/pca_tick_gen.sv ***
// Count source selection and prescaler for the shared counter
`timescale 1ns/1ps
`default_nettype none
module pca_tick_gen (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] source_sel_i,
  input wire logic six_clock_mode_i,
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  output logic tick_o
);
  logic [3:0] prescale;
  logic ext_prev;
  logic [3:0] divide;
  logic prescale_done;
  logic ext_fall;
  logic next_tick;

  assign divide = (source_sel_i == pca_pkg::SRC_OSC_SLOW) ?
                  (six_clock_mode_i ? pca_pkg::DIV_SLOW_X6 :
                                      pca_pkg::DIV_SLOW_X12) :
                  (six_clock_mode_i ? pca_pkg::DIV_FAST_X6 :
                                      pca_pkg::DIV_FAST_X12);
  assign prescale_done = (prescale >= divide - pca_pkg::DIV_ONE);
  // External input counted on its falling edge
  assign ext_fall = ext_prev & ~external_count_input_i;

  always_comb begin
    unique case (source_sel_i)
      pca_pkg::SRC_OSC_SLOW, pca_pkg::SRC_OSC_FAST: next_tick = prescale_done;
      pca_pkg::SRC_TIMER0: next_tick = timer0_overflow_i;
      pca_pkg::SRC_EXTERNAL: next_tick = ext_fall;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale <= pca_pkg::DIV_ZERO;
      ext_prev <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      prescale <= prescale_done ? pca_pkg::DIV_ZERO :
                  prescale + pca_pkg::DIV_ONE;
      ext_prev <= external_count_input_i;
      tick_o <= next_tick;
    end
  end
endmodule
`default_nettype wire

// *** design/programmable_counter_array.sv ***
// Programmable counter array: shared counter, five modules, register port
`timescale 1ns/1ps
`default_nettype none
module programmable_counter_array (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic idle_i,
  input wire logic six_clock_mode_i,
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  input wire logic [4:0] module_pin_i,
  output logic [4:0] module_pin_o,
  output logic [4:0] module_pin_oe_o,
  output logic irq_o,
  output logic internal_reset_o
);
  localparam int N = pca_pkg::NUM_MODULES;

  // Software-visible state
  logic [7:0] interrupt_enable;
  logic [7:0] counter_mode_config;
  logic counter_overflow_flag;
  logic counter_run;
  logic [N-1:0] module_event_flag;
  logic [7:0] module_mode_select [N];
  logic [15:0] counter;
  logic count_step;

  // Decode
  logic wr_ie;
  logic wr_control;
  logic wr_config;
  logic wr_count_lo;
  logic wr_count_hi;
  logic wr_count_any;
  logic mode_hit;
  logic lo_hit;
  logic hi_hit;
  logic [7:0] mode_idx;
  logic [7:0] lo_idx;
  logic [7:0] hi_idx;
  logic [N-1:0] wr_mode;
  logic [N-1:0] wr_lo;
  logic [N-1:0] wr_hi;

  // Behaviour
  logic tick;
  logic running;
  logic overflow;
  logic [15:0] next_counter;
  logic [N-1:0] module_event;
  logic [N-1:0] module_irq_enable;
  logic [15:0] module_value [N];
  logic next_overflow_flag;
  logic [N-1:0] next_event_flag;
  logic irq_request;
  logic watchdog_hit;
  logic [7:0] wdog_mode;
  logic [7:0] next_rdata;
  logic [7:0] control_byte;

  assign wr_ie = sfr_wr_i && (sfr_addr_i == pca_pkg::ADDR_IE);
  assign wr_control = sfr_wr_i && (sfr_addr_i == pca_pkg::ADDR_CONTROL);
  assign wr_config = sfr_wr_i && (sfr_addr_i == pca_pkg::ADDR_MODE_CONFIG);
  assign wr_count_lo = sfr_wr_i && (sfr_addr_i == pca_pkg::ADDR_COUNT_LO);
  assign wr_count_hi = sfr_wr_i && (sfr_addr_i == pca_pkg::ADDR_COUNT_HI);
  assign wr_count_any = wr_count_lo | wr_count_hi;
  assign mode_hit = pca_pkg::chan_hit(sfr_addr_i, pca_pkg::ADDR_MODE_BASE);
  assign lo_hit = pca_pkg::chan_hit(sfr_addr_i, pca_pkg::ADDR_VALUE_LO_BASE);
  assign hi_hit = pca_pkg::chan_hit(sfr_addr_i, pca_pkg::ADDR_VALUE_HI_BASE);
  assign mode_idx = pca_pkg::chan_offset(sfr_addr_i, pca_pkg::ADDR_MODE_BASE);
  assign lo_idx = pca_pkg::chan_offset(sfr_addr_i,
                                       pca_pkg::ADDR_VALUE_LO_BASE);
  assign hi_idx = pca_pkg::chan_offset(sfr_addr_i,
                                       pca_pkg::ADDR_VALUE_HI_BASE);

  pca_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .source_sel_i(counter_mode_config[pca_pkg::CFG_SRC_HI_BIT:
                                      pca_pkg::CFG_SRC_LO_BIT]),
    .six_clock_mode_i(six_clock_mode_i),
    .timer0_overflow_i(timer0_overflow_i),
    .external_count_input_i(external_count_input_i),
    .tick_o(tick)
  );

  assign running = counter_run &&
    !(counter_mode_config[pca_pkg::CFG_IDLE_BIT] && idle_i);
  assign overflow = tick && running && !wr_count_any &&
                    (counter == pca_pkg::WORD_ONES);

  // step; software writes win over the tick
  always_comb begin
    next_counter = counter;
    if (wr_count_any) begin
      if (wr_count_lo) next_counter[7:0] = sfr_wdata_i;
      if (wr_count_hi) next_counter[15:8] = sfr_wdata_i;
    end else if (tick && running) begin
      next_counter = counter + pca_pkg::WORD_ONE;
    end
  end

  // five modules on one time base
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mod
      assign wr_mode[g] = sfr_wr_i && mode_hit && (mode_idx == 8'(g));
      assign wr_lo[g] = sfr_wr_i && lo_hit && (lo_idx == 8'(g));
      assign wr_hi[g] = sfr_wr_i && hi_hit && (hi_idx == 8'(g));
      assign module_irq_enable[g] =
        module_mode_select[g][pca_pkg::MODE_IRQ_BIT];

      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          module_mode_select[g] <= pca_pkg::BYTE_ZERO;
        end else if (wr_mode[g]) begin
          module_mode_select[g] <= sfr_wdata_i & pca_pkg::MODE_WRITE_MASK;
        end
      end

      pca_channel u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .mode_i(module_mode_select[g]),
        .counter_i(counter),
        .count_step_i(count_step),
        .pin_i(module_pin_i[g]),
        .wr_lo_i(wr_lo[g]),
        .wr_hi_i(wr_hi[g]),
        .wdata_i(sfr_wdata_i),
        .value_o(module_value[g]),
        .event_o(module_event[g]),
        .pin_o(module_pin_o[g]),
        .pin_oe_o(module_pin_oe_o[g])
      );
    end
  endgenerate

  // flag set by overflow, cleared only by a write; set wins
  assign next_overflow_flag = overflow ? 1'b1 :
    (wr_control ? sfr_wdata_i[pca_pkg::CTRL_FLAG_BIT] : counter_overflow_flag);
  // per-module sticky flags, set wins over clear
  assign next_event_flag = module_event |
    (wr_control ? sfr_wdata_i[N-1:0] : module_event_flag);

  // per-module enables, overflow enable, array enable
  assign irq_request = interrupt_enable[pca_pkg::IE_COUNTER_ARRAY_BIT] &&
    ((counter_overflow_flag &&
      counter_mode_config[pca_pkg::CFG_OVF_IRQ_BIT]) ||
     |(module_event_flag & module_irq_enable));

  // watchdog only on module 4 compare match
  // A capture on module 4 must not reset, so the match is rebuilt here
  assign wdog_mode = module_mode_select[pca_pkg::WDOG_MODULE];
  assign watchdog_hit = counter_mode_config[pca_pkg::CFG_WDOG_BIT] &&
                        count_step && wdog_mode[pca_pkg::MODE_COMP_BIT] &&
                        wdog_mode[pca_pkg::MODE_MAT_BIT] &&
                        (counter == module_value[pca_pkg::WDOG_MODULE]);

  assign control_byte = {counter_overflow_flag, counter_run, 1'b0,
                         module_event_flag};

  // Unmapped addresses read as zero
  always_comb begin
    next_rdata = pca_pkg::BYTE_ZERO;
    if (sfr_addr_i == pca_pkg::ADDR_IE) next_rdata = interrupt_enable;
    else if (sfr_addr_i == pca_pkg::ADDR_CONTROL) next_rdata = control_byte;
    else if (sfr_addr_i == pca_pkg::ADDR_MODE_CONFIG)
      next_rdata = counter_mode_config;
    else if (sfr_addr_i == pca_pkg::ADDR_COUNT_LO) next_rdata = counter[7:0];
    else if (sfr_addr_i == pca_pkg::ADDR_COUNT_HI) next_rdata = counter[15:8];
    else if (mode_hit) next_rdata = module_mode_select[mode_idx[2:0]];
    else if (lo_hit) next_rdata = module_value[lo_idx[2:0]][7:0];
    else if (hi_hit) next_rdata = module_value[hi_idx[2:0]][15:8];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_enable <= pca_pkg::BYTE_ZERO;
      counter_mode_config <= pca_pkg::BYTE_ZERO;
      counter_run <= 1'b0;
    end else begin
      if (wr_ie) interrupt_enable <= sfr_wdata_i;
      if (wr_config)
        counter_mode_config <= sfr_wdata_i & pca_pkg::CFG_WRITE_MASK;
      if (wr_control) counter_run <= sfr_wdata_i[pca_pkg::CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter <= pca_pkg::WORD_ZERO;
      count_step <= 1'b0;
      counter_overflow_flag <= 1'b0;
      module_event_flag <= '0;
    end else begin
      counter <= next_counter;
      count_step <= tick && running && !wr_count_any;
      counter_overflow_flag <= next_overflow_flag;
      module_event_flag <= next_event_flag;
    end
  end

  // Outputs registered; reads return data one cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= pca_pkg::BYTE_ZERO;
      irq_o <= 1'b0;
      internal_reset_o <= 1'b0;
    end else begin
      sfr_rdata_o <= sfr_rd_i ? next_rdata : pca_pkg::BYTE_ZERO;
      irq_o <= irq_request;
      internal_reset_o <= watchdog_hit;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_overflow_sets_flag: assert property (
    overflow |=> counter_overflow_flag)
    else $error("overflow flag not set");
  a_flag_sw_clear: assert property (
    $fell(counter_overflow_flag) |-> $past(wr_control))
    else $error("overflow flag cleared by hardware");
  a_event_flags_sticky: assert property (
    (|($past(module_event_flag) & ~module_event_flag)) |-> $past(wr_control))
    else $error("event flag cleared by hardware");
  a_counter_steps_one: assert property (
    tick && running && !wr_count_any |=>
      counter == $past(counter) + pca_pkg::WORD_ONE)
    else $error("counter did not step by one");
  a_stopped_holds: assert property (
    !counter_run && !wr_count_any |=> counter == $past(counter))
    else $error("counter moved while stopped");
  a_idle_halts: assert property (
    counter_mode_config[pca_pkg::CFG_IDLE_BIT] && idle_i && !wr_count_any
      |=> $stable(counter))
    else $error("counter moved in idle");
  a_irq_gated_off: assert property (
    !interrupt_enable[pca_pkg::IE_COUNTER_ARRAY_BIT] |=> !irq_o)
    else $error("interrupt passed while disabled");
  a_ovf_irq_raised: assert property (
    interrupt_enable[pca_pkg::IE_COUNTER_ARRAY_BIT] &&
    counter_mode_config[pca_pkg::CFG_OVF_IRQ_BIT] && overflow |=> ##1 irq_o)
    else $error("overflow interrupt missing");
  a_watchdog_gate: assert property (
    !counter_mode_config[pca_pkg::CFG_WDOG_BIT] |=> !internal_reset_o)
    else $error("watchdog reset while disabled");
  a_watchdog_fires: assert property (
    watchdog_hit |=> internal_reset_o)
    else $error("watchdog reset missing");

  a_event_sets_flag: assert property (
    |module_event |=>
      (module_event_flag & $past(module_event)) == $past(module_event))
    else $error("module event flag not set");
  a_module_irq: assert property (
    interrupt_enable[pca_pkg::IE_COUNTER_ARRAY_BIT] &&
    |(module_event_flag & module_irq_enable) |=> irq_o)
    else $error("module interrupt missing");
  // Read data stands one cycle only
  a_rdata_idle_zero: assert property (
    !sfr_rd_i |=> sfr_rdata_o == pca_pkg::BYTE_ZERO)
    else $error("read data without a read");
  c_overflow_seen: cover property (overflow);
  c_watchdog_seen: cover property (watchdog_hit);
  c_irq_seen: cover property (irq_o);
endmodule
`default_nettype wire

// *** verification/pca_core_model.sv ***
// Processor side model: register port cycles, timer 0, count input, pins
`timescale 1ns/1ps
`default_nettype none
module pca_core_model (
  input wire logic ref_clk_i,
  input wire logic [4:0] pin_drv_i,
  input wire logic [4:0] pin_oe_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  output logic t0_o,
  output logic eci_o,
  output logic [4:0] pin_o
);
  logic [4:0] ext_lvl;
  // Board level only counts where no module drives the pin
  assign pin_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_lvl);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    t0_o = 1'b0;
    eci_o = 1'b1;
    ext_lvl = 5'h1F;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge ref_clk_i);
    d = rdata_i;
    rd_o = 1'b0;
  endtask
  // Settle time covers tick delay, step, match and flag update
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge ref_clk_i);
      t0_o = 1'b1;
      @(negedge ref_clk_i);
      t0_o = 1'b0;
      repeat (6) @(negedge ref_clk_i);
    end
  endtask
  task automatic eci_fall(input int k);
    repeat (k) begin
      @(negedge ref_clk_i);
      eci_o = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      eci_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask
  // Random levels for one cycle, only while the counter is stopped
  task automatic jitter(input logic [1:0] r);
    @(negedge ref_clk_i);
    t0_o = r[0];
    eci_o = r[1];
    @(negedge ref_clk_i);
    t0_o = 1'b0;
    eci_o = 1'b1;
  endtask
  task automatic set_pin(input int n, input logic v);
    @(negedge ref_clk_i);
    ext_lvl[n] = v;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the programmable counter array
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i, rst_n_i, idle, six, wr, rd, t0, external_count_input, irq, wdog;
  logic [7:0] addr, wdata, rdata, m, d;
  logic [4:0] pin_in, pin_out, pin_oe;
  logic [15:0] x, y;
  int num_errors, n_tests, seed, wdog_cnt, n, k, e;
  programmable_counter_array programmable_counter_array_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .idle_i(idle), .six_clock_mode_i(six),
    .timer0_overflow_i(t0), .external_count_input_i(external_count_input),
    .module_pin_i(pin_in), .module_pin_o(pin_out),
    .module_pin_oe_o(pin_oe), .irq_o(irq), .internal_reset_o(wdog));
  pca_core_model pca_core_model_inst (
    .ref_clk_i(ref_clk_i), .pin_drv_i(pin_out), .pin_oe_i(pin_oe),
    .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .t0_o(t0), .eci_o(external_count_input), .pin_o(pin_in));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (wdog === 1'b1) wdog_cnt++;
  end
  function automatic int exp_div(input logic fast, input logic s6);
    exp_div = fast ? (s6 ? 2 : 4) : (s6 ? 6 : 12);
  endfunction
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    pca_core_model_inst.write(a, v);
  endtask
  task automatic rc(input string what, input logic [7:0] a,
                    input logic [7:0] exp);
    logic [7:0] v;
    pca_core_model_inst.read(a, v);
    check(what, {8'h00, exp}, {8'h00, v});
  endtask
  task automatic pair(input logic [7:0] lo, input logic [15:0] v);
    w(lo, v[7:0]);
    w(lo + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi,
                      output logic [15:0] v);
    pca_core_model_inst.read(lo, v[7:0]);
    pca_core_model_inst.read(hi, v[15:8]);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    seed = 73;
    rst_n_i = 1'b0;
    idle = 1'($random(seed));
    six = 1'($random(seed));
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    check("pin idle", 16'h001F, {11'h000, pin_out});
    repeat (4) pca_core_model_inst.jitter(2'($random(seed)));
    rc("control reset", pca_pkg::ADDR_CONTROL, 8'h00);
    w(8'hC4, 8'hFF);
    rc("unmapped", 8'hC4, 8'h00);
    for (n = 0; n < 5; n++) begin
      d = 8'($random(seed));
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), d);
      rc("mode", pca_pkg::ADDR_MODE_BASE + 8'(n), d & 8'h7F);
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), 8'h00);
      x = 16'($random(seed));
      w(pca_pkg::ADDR_VALUE_LO_BASE + 8'(n), x[7:0]);
      w(pca_pkg::ADDR_VALUE_HI_BASE + 8'(n), x[15:8]);
      rd16(pca_pkg::ADDR_VALUE_LO_BASE + 8'(n),
           pca_pkg::ADDR_VALUE_HI_BASE + 8'(n), y);
      check("value pair", x, y);
    end
    d = 8'($random(seed));
    w(pca_pkg::ADDR_MODE_CONFIG, d);
    rc("config", pca_pkg::ADDR_MODE_CONFIG, d & 8'hC7);
    // Timer 0 source gives an exact step count
    w(pca_pkg::ADDR_MODE_CONFIG, 8'h04);
    x = 16'($random(seed)) & 16'h7FFF;
    k = 1 + ($unsigned($random(seed)) % 8);
    pair(pca_pkg::ADDR_COUNT_LO, x);
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    pca_core_model_inst.pulse(k);
    rd16(pca_pkg::ADDR_COUNT_LO, pca_pkg::ADDR_COUNT_HI, y);
    check("timer0 count", x + 16'(k), y);
    w(pca_pkg::ADDR_CONTROL, 8'h00);
    pca_core_model_inst.pulse(2);
    rd16(pca_pkg::ADDR_COUNT_LO, pca_pkg::ADDR_COUNT_HI, x);
    check("stopped", y, x);
    w(pca_pkg::ADDR_MODE_CONFIG, 8'h84);
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    idle = 1'b1;
    pca_core_model_inst.pulse(2);
    idle = 1'b0;
    rd16(pca_pkg::ADDR_COUNT_LO, pca_pkg::ADDR_COUNT_HI, x);
    check("idle stop", y, x);
    for (k = 0; k < 4; k++) begin
      w(pca_pkg::ADDR_CONTROL, 8'h00);
      six = k[0];
      w(pca_pkg::ADDR_MODE_CONFIG, {6'h00, k[1], 1'b0});
      pair(pca_pkg::ADDR_COUNT_LO, 16'h0000);
      w(pca_pkg::ADDR_CONTROL, 8'h40);
      cyc(120);
      w(pca_pkg::ADDR_CONTROL, 8'h00);
      rd16(pca_pkg::ADDR_COUNT_LO, pca_pkg::ADDR_COUNT_HI, x);
      e = 121 / exp_div(k[1], k[0]);
      check("osc rate", 16'h0001, {15'h0, (x + 2 >= e) && (x <= e + 2)});
    end
    w(pca_pkg::ADDR_MODE_CONFIG, 8'h06);
    pair(pca_pkg::ADDR_COUNT_LO, 16'h0000);
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    pca_core_model_inst.eci_fall(3);
    rc("ext count", pca_pkg::ADDR_COUNT_LO, 8'h03);
    // Overflow: flag and request stay until software clears them
    w(pca_pkg::ADDR_CONTROL, 8'h00);
    w(pca_pkg::ADDR_MODE_CONFIG, 8'h05);
    w(pca_pkg::ADDR_IE, 8'h40);
    pair(pca_pkg::ADDR_COUNT_LO, 16'hFFFF);
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    pca_core_model_inst.pulse(1);
    rc("wrap", pca_pkg::ADDR_COUNT_HI, 8'h00);
    cyc(20);
    rc("overflow flag", pca_pkg::ADDR_CONTROL, 8'hC0);
    check("ovf irq", 16'h0001, {15'h0, irq});
    w(pca_pkg::ADDR_IE, 8'h00);
    cyc(3);
    check("irq gated", 16'h0000, {15'h0, irq});
    w(pca_pkg::ADDR_IE, 8'h40);
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    rc("flag cleared", pca_pkg::ADDR_CONTROL, 8'h40);
    w(pca_pkg::ADDR_MODE_CONFIG, 8'h04);
    for (n = 0; n < 5; n++) begin
      x = 16'($random(seed)) & 16'h7FFF;
      w(pca_pkg::ADDR_CONTROL, 8'h00);
      pair(pca_pkg::ADDR_COUNT_LO, x);
      w(pca_pkg::ADDR_VALUE_LO_BASE + 8'(n), x[7:0] + 8'h02);
      w(pca_pkg::ADDR_VALUE_HI_BASE + 8'(n), 8'((x + 16'h0002) >> 8));
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), 8'h4D);
      w(pca_pkg::ADDR_CONTROL, 8'h40);
      pca_core_model_inst.pulse(1);
      rc("no early match", pca_pkg::ADDR_CONTROL, 8'h40);
      pca_core_model_inst.pulse(1);
      rc("match flag", pca_pkg::ADDR_CONTROL, 8'h40 | (8'h01 << n));
      check("toggle", 16'h0000, {15'h0, pin_out[n]});
      check("module irq", 16'h0001, {15'h0, irq});
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), 8'h00);
    end
    for (n = 0; n < 5; n++) begin
      m = (n % 3 == 0) ? 8'h20 : ((n % 3 == 1) ? 8'h10 : 8'h30);
      x = 16'($random(seed));
      w(pca_pkg::ADDR_CONTROL, 8'h00);
      pair(pca_pkg::ADDR_COUNT_LO, x);
      pca_core_model_inst.set_pin(n, m == 8'h10);
      cyc(3);
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), m);
      pca_core_model_inst.set_pin(n, m != 8'h10);
      cyc(4);
      rd16(pca_pkg::ADDR_VALUE_LO_BASE + 8'(n),
           pca_pkg::ADDR_VALUE_HI_BASE + 8'(n), y);
      check("capture", x, y);
      rc("capture flag", pca_pkg::ADDR_CONTROL, 8'h01 << n);
      w(pca_pkg::ADDR_MODE_BASE + 8'(n), 8'h00);
      pca_core_model_inst.set_pin(n, 1'b1);
    end
    // Module 2 as PWM: duty from low byte, reload from high at wrap
    w(pca_pkg::ADDR_CONTROL, 8'h00);
    pair(pca_pkg::ADDR_COUNT_LO, 16'h0010);
    w(pca_pkg::ADDR_VALUE_LO_BASE + 8'h02, 8'h80);
    w(pca_pkg::ADDR_VALUE_HI_BASE + 8'h02, 8'h40);
    w(pca_pkg::ADDR_MODE_BASE + 8'h02, 8'h42);
    cyc(4);
    check("pwm low", 16'h0001, {14'h0, pin_out[2], pin_oe[2]});
    w(pca_pkg::ADDR_COUNT_LO, 8'hFF);
    cyc(4);
    check("pwm high", 16'h0001, {15'h0, pin_out[2]});
    w(pca_pkg::ADDR_CONTROL, 8'h40);
    pca_core_model_inst.pulse(1);
    rc("pwm reload", pca_pkg::ADDR_VALUE_LO_BASE + 8'h02, 8'h40);
    check("pwm after wrap", 16'h0000, {15'h0, pin_out[2]});
    // Watchdog: a module 4 match resets only while enabled
    for (k = 0; k < 2; k++) begin
      w(pca_pkg::ADDR_CONTROL, 8'h00);
      w(pca_pkg::ADDR_MODE_CONFIG, k ? 8'h44 : 8'h04);
      pair(pca_pkg::ADDR_COUNT_LO, 16'h1233);
      w(pca_pkg::ADDR_VALUE_LO_BASE + 8'h04, 8'h34);
      w(pca_pkg::ADDR_VALUE_HI_BASE + 8'h04, 8'h12);
      w(pca_pkg::ADDR_MODE_BASE + 8'h04, 8'h48);
      w(pca_pkg::ADDR_CONTROL, 8'h40);
      pca_core_model_inst.pulse(1);
      check("wdog reset", 16'(k), 16'(wdog_cnt));
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
